// ==== design/card_strobe_cfg.svh ====
// Timing counts for the card socket strobe sequencer
`ifndef CARD_STROBE_CFG_SVH
`define CARD_STROBE_CFG_SVH
`define CSS_NUM_SLOTS     2
`define CSS_CNT_W         4
`define CSS_SETUP_CYC     4'h2
`define CSS_STROBE_CYC    4'h4
`define CSS_HOLD_CYC      4'h2
`define CSS_LANE_EVEN     0
`define CSS_LANE_ODD      1
`endif

// ==== design/card_strobe_pkg.sv ====
// Types shared by the card socket strobe sequencer
package card_strobe_pkg;
  // Kind of socket cycle requested by the host side
  typedef enum logic [2:0] {
    CYC_MEM_RD,
    CYC_MEM_WR,
    CYC_ATTR_RD,
    CYC_ATTR_WR,
    CYC_IO_RD,
    CYC_IO_WR,
    CYC_DMA_TO_HOST,
    CYC_DMA_TO_CARD
  } cycle_e;

  // Host side request for one slot
  typedef struct packed {
    logic       valid;
    cycle_e     kind;
    logic [1:0] lanes;   // Bit 0 even lane, bit 1 odd lane
    logic       tc;      // Last DMA transfer
  } req_s;

  // Strobe pins of one slot, all active low
  typedef struct packed {
    logic ce1_n;
    logic ce2_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic reg_n;
  } pins_s;

  // Card driven inputs of one slot, active low
  typedef struct packed {
    logic wait_n;
    logic inpack_n;
  } card_in_s;

  // Status returned to the host side
  typedef struct packed {
    logic busy;
    logic done;
    logic dma_req;
    logic inpack;
  } stat_s;
endpackage : card_strobe_pkg

// ==== design/card_socket_strobe_control.sv ====
// Strobe sequencer for two 16-bit card sockets
`timescale 1ns/1ps
`default_nettype none
`include "card_strobe_cfg.svh"

module card_socket_strobe_control #(
  parameter int NUM_SLOTS = `CSS_NUM_SLOTS  // Socket count
) (
  input  wire logic                       i_clk,      // System clock
  input  wire logic                       i_reset_n,  // Async reset
  input  wire card_strobe_pkg::req_s      i_req    [NUM_SLOTS],
  input  wire logic                       i_dma_mode [NUM_SLOTS],
  input  wire card_strobe_pkg::card_in_s  i_card   [NUM_SLOTS],
  output var  card_strobe_pkg::pins_s     o_pins   [NUM_SLOTS],
  output var  card_strobe_pkg::stat_s     o_stat   [NUM_SLOTS]
);
  import card_strobe_pkg::*;

  localparam int CW = `CSS_CNT_W;  // Phase counter width

  // Lane enables from the requested lanes
  function automatic logic [1:0] lane_n(input logic [1:0] lanes);
    logic [1:0] act;
    // An empty lane mask counts as a word access
    act = (lanes == 2'h0) ? 2'h3 : lanes;
    lane_n = ~act;
  endfunction : lane_n

  // True for cycles that touch common memory
  function automatic logic is_common(input cycle_e k);
    // Attribute, I/O and DMA cycles all drive REG low
    is_common = (k == CYC_MEM_RD) || (k == CYC_MEM_WR);
  endfunction : is_common

  // Strobe pattern for one cycle kind in the strobe phase
  function automatic pins_s strobe_pins(input req_s r);
    pins_s p;
    logic [1:0] ln;
    p  = '1;
    ln = lane_n(r.lanes);
    // Selects follow the lanes, REG follows the space
    p.ce1_n = ln[`CSS_LANE_EVEN];
    p.ce2_n = ln[`CSS_LANE_ODD];
    p.reg_n = is_common(r.kind);
    // One strobe per kind; DMA to host adds OE on terminal count
    unique case (r.kind)
      CYC_MEM_RD, CYC_ATTR_RD: p.oe_n = 1'b0;
      CYC_MEM_WR, CYC_ATTR_WR: p.we_n = 1'b0;
      CYC_IO_RD:               p.iord_n = 1'b0;
      CYC_IO_WR:               p.iowr_n = 1'b0;
      CYC_DMA_TO_HOST: begin
        p.iord_n = 1'b0;
        p.oe_n   = ~r.tc;
        p.reg_n  = 1'b0;
      end
      CYC_DMA_TO_CARD: begin
        p.iowr_n = 1'b0;
        p.reg_n  = 1'b0;
      end
    endcase
    strobe_pins = p;
  endfunction : strobe_pins

  // One strobe set per slot, no shared state
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
    } state_e;

    // Per slot state; nothing here is shared between slots
    state_e          state_q, state_d;  // Sequencer state
    logic [CW-1:0]   cnt_q, cnt_d;      // Phase cycle counter
    req_s            req_q, req_d;      // Latched request
    pins_s           pins_q, pins_d;    // Registered strobes
    stat_s           stat_q, stat_d;    // Registered status
    card_in_s        sync1_q, sync2_q, sync3_q;  // Pin synchroniser
    card_in_s        filt_q, filt_d;    // Agreed pin levels
    logic [1:0]      take_ln_n;         // Lane enables, new request

    // Filtered level moves once stages two and three agree
    always_comb begin
      filt_d = filt_q;
      if (sync2_q.wait_n == sync3_q.wait_n) begin
        filt_d.wait_n = sync3_q.wait_n;
      end
      if (sync2_q.inpack_n == sync3_q.inpack_n) begin
        filt_d.inpack_n = sync3_q.inpack_n;
      end
    end

    // Three stage pin synchroniser and filter register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        // Pins read as released until the card drives
        sync1_q <= '1;
        sync2_q <= '1;
        sync3_q <= '1;
        filt_q  <= '1;
      end else begin
        sync1_q <= i_card[s];
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
        filt_q  <= filt_d;
      end
    end

    // Next state of the cycle sequencer
    always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      req_d   = req_q;
      pins_d  = pins_q;
      stat_d  = stat_q;
      // Lane enables a new request would drive
      take_ln_n = lane_n(i_req[s].lanes);
      stat_d.done = 1'b0;
      // DMA request follows INPACK only in DMA mode
      stat_d.dma_req = i_dma_mode[s] && !filt_q.inpack_n;
      // Acknowledge is trusted only during an I/O read
      stat_d.inpack = !i_dma_mode[s] && !filt_q.inpack_n &&
                      (state_q == ST_STROBE) &&
                      (req_q.kind == CYC_IO_RD);
      unique case (state_q)
        ST_IDLE: begin
          // Take a new request, raise select lines
          if (i_req[s].valid) begin
            req_d        = i_req[s];
            pins_d       = '1;
            pins_d.ce1_n = take_ln_n[`CSS_LANE_EVEN];
            pins_d.ce2_n = take_ln_n[`CSS_LANE_ODD];
            pins_d.reg_n = is_common(i_req[s].kind);
            if (i_req[s].kind inside {CYC_DMA_TO_HOST,
                                      CYC_DMA_TO_CARD}) begin
              pins_d.reg_n = 1'b0;
            end
            // Setup count starts with the selects
            cnt_d        = `CSS_SETUP_CYC;
            stat_d.busy  = 1'b1;
            state_d      = ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and selects settle before the strobe
          if (cnt_q == '0) begin
            pins_d  = strobe_pins(req_q);
            cnt_d   = `CSS_STROBE_CYC;
            state_d = ST_STROBE;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        ST_STROBE: begin
          // Minimum width, then stay while the card waits
          // WAIT arrives about four cycles late, so a card
          // must raise it within the first cycle of the strobe
          if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
          end else if (filt_q.wait_n) begin
            // Strobes end; selects stay asserted for the hold
            pins_d.oe_n   = 1'b1;
            pins_d.we_n   = 1'b1;
            pins_d.iord_n = 1'b1;
            pins_d.iowr_n = 1'b1;
            cnt_d         = `CSS_HOLD_CYC;
            state_d       = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Selects held past the strobe, then release
          if (cnt_q == '0) begin
            pins_d      = '1;
            stat_d.busy = 1'b0;
            stat_d.done = 1'b1;
            state_d     = ST_IDLE;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        // Idle, every strobe and select released
        state_q <= ST_IDLE;
        cnt_q   <= '0;
        req_q   <= '0;
        pins_q  <= '1;
        stat_q  <= '0;
      end else begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
        req_q   <= req_d;
        pins_q  <= pins_d;
        stat_q  <= stat_d;
      end
    end

    // Outputs come straight from flip-flops
    assign o_pins[s] = pins_q;
    assign o_stat[s] = stat_q;
  end : g_slot
endmodule : card_socket_strobe_control
`default_nettype wire

// ==== sim/card_strobe_monitor.sv ====
// Assertion checker for the card socket strobe sequencer
`timescale 1ns/1ps
`default_nettype none
module card_strobe_monitor #(
  parameter int NUM_SLOTS = 2  // Socket count
) (
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire card_strobe_pkg::req_s     i_req [NUM_SLOTS],
  input wire logic                      i_dma_mode [NUM_SLOTS],
  input wire card_strobe_pkg::card_in_s i_card [NUM_SLOTS],
  input wire card_strobe_pkg::pins_s    o_pins [NUM_SLOTS],
  input wire card_strobe_pkg::stat_s    o_stat [NUM_SLOTS]
);
  import card_strobe_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic       tk = i_req[0].valid & ~o_stat[0].busy;  // Slot 0 take
  wire logic [2:0] k  = i_req[0].kind;                      // Cycle kind
  wire logic [1:0] ln = i_req[0].lanes;                     // Lane select
  wire pins_s      p  = o_pins[0];                          // Slot 0 pins
  chk_word_lanes: assert property (
    tk && ln == 2'h3 |=> !p.ce1_n && !p.ce2_n) else $error("Word lanes");
  chk_even_lane: assert property (
    tk && ln == 2'h1 |=> !p.ce1_n && p.ce2_n) else $error("Even lane");
  chk_odd_lane: assert property (
    tk && ln == 2'h2 |=> p.ce1_n && !p.ce2_n) else $error("Odd lane");
  chk_io_read: assert property (
    tk && k == CYC_IO_RD |=> !p.reg_n ##3 !p.iord_n) else $error("IO read");
  chk_io_write: assert property (
    tk && k == CYC_IO_WR |=> ##3 !p.iowr_n) else $error("IO write");
  chk_mem_read: assert property (
    tk && k == CYC_MEM_RD |=> p.reg_n ##3 !p.oe_n) else $error("Mem read");
  chk_dma_host: assert property (
    tk && k == CYC_DMA_TO_HOST && i_req[0].tc |=> !p.reg_n ##3
    !p.iord_n && !p.oe_n) else $error("DMA to host");
  chk_dma_card: assert property (
    tk && k == CYC_DMA_TO_CARD |=> !p.reg_n ##3 !p.iowr_n)
    else $error("DMA to card");
endmodule : card_strobe_monitor
bind card_socket_strobe_control card_strobe_monitor #(
  .NUM_SLOTS(NUM_SLOTS)) mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_req(i_req), .i_dma_mode(i_dma_mode), .i_card(i_card),
  .o_pins(o_pins), .o_stat(o_stat));
`default_nettype wire

// ==== sim/card_model.sv ====
// Behavioural card standing on one socket
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input wire logic                    i_clk,
  input wire card_strobe_pkg::pins_s  i_pins,
  input wire logic [3:0]              i_wait_len,  // Wait cycles per strobe
  input wire logic                    i_ack,       // Address decoded
  input wire logic                    i_dreq,      // DMA wanted
  output var card_strobe_pkg::card_in_s o_card
);
  import card_strobe_pkg::*;
  logic [4:0] age_q = 5'h0;  // Cycles since strobe began
  wire logic  stb = !(i_pins.oe_n & i_pins.we_n & i_pins.iord_n &
                      i_pins.iowr_n);
  // Strobe age counter
  always @(posedge i_clk) begin
    age_q <= stb ? age_q + 5'h1 : 5'h0;
  end
  // Wait while strobe is young; ack IORD with REG low (I/O read, DMA to host) or ask DMA
  assign o_card = {!(stb && age_q < {1'b0, i_wait_len}),
                   !(i_dreq | i_ack & !i_pins.iord_n &
                     !i_pins.reg_n)};
endmodule : card_model
`default_nettype wire

// ==== sim/card_socket_strobe_control_tb_top.sv ====
// Self-checking bench for the card socket strobe sequencer
`timescale 1ns/1ps
`default_nettype none
module card_socket_strobe_control_tb_top;
  import card_strobe_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  req_s       req [2];
  logic       dma [2];
  card_in_s   card [2];
  pins_s      pins [2];
  stat_s      stat [2];
  logic [3:0] wlen [2];
  logic       ack [2];
  logic       dreq [2];
  int         err_total = 0;
  int         check_count = 0;
  always #2.5 i_clk = ~i_clk;
  card_socket_strobe_control dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_req(req), .i_dma_mode(dma), .i_card(card), .o_pins(pins),
    .o_stat(stat));
  for (genvar s = 0; s < 2; s++) begin : g_card
    card_model card_m (.i_clk(i_clk), .i_pins(pins[s]), .i_wait_len(wlen[s]),
      .i_ack(ack[s]), .i_dreq(dreq[s]), .o_card(card[s]));
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Pins expected to fall at least once during a cycle
  function automatic pins_s exp_pins(cycle_e k, logic [1:0] ln, logic tc);
    exp_pins = '1;
    exp_pins.ce1_n = !ln[0];
    exp_pins.ce2_n = !ln[1];
    exp_pins.reg_n = k inside {CYC_MEM_RD, CYC_MEM_WR};
    exp_pins.oe_n = !(k inside {CYC_MEM_RD, CYC_ATTR_RD}
                      || k == CYC_DMA_TO_HOST && tc);
    exp_pins.we_n = !(k inside {CYC_MEM_WR, CYC_ATTR_WR});
    exp_pins.iord_n = !(k inside {CYC_IO_RD, CYC_DMA_TO_HOST});
    exp_pins.iowr_n = !(k inside {CYC_IO_WR, CYC_DMA_TO_CARD});
  endfunction : exp_pins
  // One socket cycle; counts cycles to done, gathers fallen pins
  task automatic run(int s, cycle_e k, logic [1:0] ln, logic tc,
                     output int n, output pins_s sn, output logic ip);
    pins_s oth;
    oth = '1;
    sn = '1;
    ip = 1'b0;
    n = 0;
    @(posedge i_clk) req[s] <= '{1'b1, k, ln, tc};
    @(posedge i_clk) req[s].valid <= 1'b0;
    while (n < 60 && stat[s].done !== 1'b1) begin
      @(negedge i_clk);
      n++;
      sn &= pins[s];
      oth &= pins[1-s];
      ip |= stat[s].inpack;
      if (n == 1) check(stat[s].busy, 1'b1);
    end
    if (stat[s].done !== 1'b1) begin
      err_total++;
      test_done;
    end
    check(pins[s], 32'h7f);
    check(oth, 32'h7f);
    check(stat[s].busy, 1'b0);
  endtask : run
  // Every kind on every lane mix, both slots
  task automatic t_kinds;
    int n;
    pins_s sn;
    logic ip;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        for (int l = 0; l < 4; l++) begin
          run(s, cycle_e'(k), l[1:0], l == 3, n, sn, ip);
          // An empty lane mask is a word access
          check(sn, exp_pins(cycle_e'(k), l ? l[1:0] : 2'h3, l == 3));
          check(n, 12);
          check(ip, k == CYC_IO_RD);
        end
      end
    end
  endtask : t_kinds
  // Card holds the strobe with wait
  task automatic t_wait;
    int n;
    pins_s sn;
    logic ip;
    @(posedge i_clk) wlen[0] <= 4'ha;
    run(0, CYC_IO_RD, 2'h3, 1'b0, n, sn, ip);
    check(n > 12, 1'b1);
    @(posedge i_clk) wlen[0] <= 4'h0;
  endtask : t_wait
  // Input acknowledge used as DMA request
  task automatic t_dma;
    int n;
    pins_s sn;
    logic ip;
    @(posedge i_clk) dma[0] <= 1'b1;
    dreq[0] <= 1'b1;
    for (int i = 0; i < 8 && stat[0].dma_req !== 1'b1; i++) @(negedge i_clk);
    check(stat[0].dma_req, 1'b1);
    check(stat[1].dma_req, 1'b0);
    @(posedge i_clk) dreq[0] <= 1'b0;
    for (int i = 0; i < 8 && stat[0].dma_req !== 1'b0; i++) @(negedge i_clk);
    check(stat[0].dma_req, 1'b0);
    run(0, CYC_DMA_TO_HOST, 2'h3, 1'b0, n, sn, ip);
    check(ip, 1'b0);
    check(sn, exp_pins(CYC_DMA_TO_HOST, 2'h3, 1'b0));
  endtask : t_dma
  initial begin
    for (int s = 0; s < 2; s++) begin
      req[s] = '0;
      dma[s] = 1'b0;
      wlen[s] = 4'h0;
      ack[s] = 1'b1;
      dreq[s] = 1'b0;
    end
    repeat (2) @(posedge i_clk);
    check(pins[0], 32'h7f);
    i_reset_n <= 1'b1;
    t_kinds;
    t_wait;
    t_dma;
    test_done;
  end
endmodule : card_socket_strobe_control_tb_top
`default_nettype wire
